// *** dbu_pkg.sv ***
// Register map, field layout and shared types of the debug breakpoint unit.
`default_nettype none
package dbu_pkg;
   localparam int unsigned NUM_THREADS = 8;
   localparam int unsigned NUM_IBRK    = 4;
   localparam int unsigned NUM_SCR     = 8;
   localparam int unsigned THR_SEL_W   = 3;
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned IDX_W       = 10;
   localparam int unsigned IDX_LSB     = 2;

   typedef logic [IDX_W-1:0] dbu_idx_t;

   // Register indices; the byte address is four times the index.
   localparam dbu_idx_t IDX_SAVED_STAT = 10'h010;
   localparam dbu_idx_t IDX_SAVED_PC   = 10'h011;
   localparam dbu_idx_t IDX_SAVED_SP   = 10'h012;
   localparam dbu_idx_t IDX_FETCH_THR  = 10'h013;
   localparam dbu_idx_t IDX_FETCH_REG  = 10'h014;
   localparam dbu_idx_t IDX_CAUSE      = 10'h015;
   localparam dbu_idx_t IDX_CAUSE_DATA = 10'h016;
   localparam dbu_idx_t IDX_STOP_MASK  = 10'h018;
   localparam dbu_idx_t IDX_SCRATCH    = 10'h020;
   localparam dbu_idx_t IDX_IBRK_TGT   = 10'h030;
   localparam dbu_idx_t IDX_IBRK_SETUP = 10'h040;
   localparam dbu_idx_t IDX_IRQ_STAT   = 10'h0a0;
   localparam dbu_idx_t IDX_IRQ_MASK   = 10'h0a1;

   // Saved status word layout.
   localparam int unsigned STAT_W         = 11;
   localparam int unsigned STAT_RSVD_BIT  = 5;
   localparam int unsigned STAT_ISSUE_BIT = 8;
   localparam logic [STAT_W-1:0] STAT_CAP_MASK = 11'h7df;
   localparam logic [STAT_W-1:0] STAT_WR_MASK  = 11'h6df;

   localparam int unsigned FETCH_REG_W = 5;

   // Cause register layout and codes.
   localparam int unsigned CAUSE_CODE_LSB = 0;
   localparam int unsigned CAUSE_THR_LSB  = 8;
   localparam int unsigned CAUSE_IDX_LSB  = 16;
   typedef logic [2:0] dbu_code_t;
   localparam dbu_code_t CAUSE_NONE   = 3'h0;
   localparam dbu_code_t CAUSE_HOST   = 3'h1;
   localparam dbu_code_t CAUSE_CALL   = 3'h2;
   localparam dbu_code_t CAUSE_IBRK   = 3'h3;
   localparam dbu_code_t CAUSE_DWATCH = 3'h4;
   localparam dbu_code_t CAUSE_RWATCH = 3'h5;

   // Breakpoint setup layout.
   localparam int unsigned IBC_EN_BIT   = 0;
   localparam int unsigned IBC_NE_BIT   = 1;
   localparam int unsigned IBC_MASK_LSB = 16;

   // Interrupt status bits.
   localparam int unsigned IRQ_W      = 3;
   localparam int unsigned IRQ_ENTRY  = 0;
   localparam int unsigned IRQ_RETURN = 1;
   localparam int unsigned IRQ_DROP   = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0]             idx;
      logic [NUM_THREADS-1:0] thread;
      dbu_code_t              code;
   } dbu_cause_t;

   typedef struct packed {
      logic [NUM_THREADS-1:0] mask;
      logic                   ne;
      logic                   en;
   } dbu_ibc_t;

   typedef struct packed {
      logic [STAT_W-1:0] status;
      logic [31:0]       pc;
      logic [31:0]       sp;
   } dbu_snap_t;

   typedef struct packed {
      logic                   valid;
      logic [1:0]             idx;
      logic [NUM_THREADS-1:0] thread;
      logic [31:0]            data;
   } dbu_evt_t;

   typedef struct packed {
      logic [STAT_W-1:0]                saved_status_word;
      logic [31:0]                      saved_program_counter_word;
      logic [31:0]                      saved_stack_pointer_word;
      logic [NUM_THREADS-1:0]           fetch_thr;
      logic [FETCH_REG_W-1:0]           fetch_reg;
      dbu_cause_t                       cause;
      logic [31:0]                      cause_data;
      logic [NUM_THREADS-1:0]           stop;
      logic [NUM_SCR-1:0][31:0]         scr;
      logic [NUM_IBRK-1:0][31:0]        ibt;
      dbu_ibc_t [NUM_IBRK-1:0]          ibc;
      logic                             in_dbg;
      logic [NUM_THREADS-1:0]           stop_out;
      logic [IRQ_W-1:0]                 istat;
      logic [IRQ_W-1:0]                 imask;
      logic                             irq;
      logic [31:0]                      cfg_rdata;
      logic                             awready;
      logic                             wready;
      logic                             aw_got;
      logic                             w_got;
      dbu_idx_t                         aw_idx;
      logic [31:0]                      w_data;
      logic [3:0]                       w_strb;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             arready;
      logic                             rvalid;
      logic [31:0]                      rdata;
      logic [1:0]                       rresp;
   } dbu_state_t;
endpackage : dbu_pkg
`default_nettype wire

// *** dbu_ibrk_cmp.sv ***
// One instruction breakpoint comparator against the issuing thread.
`timescale 1ns/1ns
`default_nettype none
module dbu_ibrk_cmp
   import dbu_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   valid_i,
   input  wire logic [31:0]            pc_i,
   input  wire logic [NUM_THREADS-1:0] thread_i,
   input  wire logic [31:0]            target_i,
   input  wire dbu_ibc_t               cfg_i,
   output logic                        hit_o
);
   logic thr_ok;
   logic pc_eq;

   // Thread numbers beyond the mask width can never match.
   assign thr_ok = (thread_i[NUM_THREADS-1:THR_SEL_W] == '0) &&
                   cfg_i.mask[thread_i[THR_SEL_W-1:0]];
   assign pc_eq  = (pc_i == target_i);
   assign hit_o  = valid_i && cfg_i.en && thr_ok &&
                   (pc_eq != cfg_i.ne);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_enable_gate: assert property (!cfg_i.en |-> !hit_o)
      else $error("Disabled breakpoint fired.");
   a_thread_gate: assert property (
      hit_o |-> cfg_i.mask[thread_i[THR_SEL_W-1:0]])
      else $error("Breakpoint fired for a thread not enabled.");
   a_mode_select: assert property (
      (valid_i && cfg_i.en && thr_ok) |-> (hit_o == (pc_eq ^ cfg_i.ne)))
      else $error("Breakpoint compare mode wrong.");
endmodule : dbu_ibrk_cmp
`default_nettype wire

// *** dbu_top.sv ***
// Debug breakpoint unit: capture on debug entry, breakpoints, AXI registers.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dbu_top
   import dbu_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire logic [ADDR_W-1:0]      axi_awaddr_i,
   input  wire logic                   axi_awvalid_i,
   output logic                        axi_awready_o,
   input  wire logic [31:0]            axi_wdata_i,
   input  wire logic [3:0]             axi_wstrb_i,
   input  wire logic                   axi_wvalid_i,
   output logic                        axi_wready_o,
   output logic [1:0]                  axi_bresp_o,
   output logic                        axi_bvalid_o,
   input  wire logic                   axi_bready_i,
   input  wire logic [ADDR_W-1:0]      axi_araddr_i,
   input  wire logic                   axi_arvalid_i,
   output logic                        axi_arready_o,
   output logic [31:0]                 axi_rdata_o,
   output logic [1:0]                  axi_rresp_o,
   output logic                        axi_rvalid_o,
   input  wire logic                   axi_rready_i,
   input  wire logic                   exec_valid_i,
   input  wire logic [31:0]            exec_pc_i,
   input  wire logic [NUM_THREADS-1:0] exec_thread_i,
   input  wire dbu_snap_t              snap_i,
   input  wire logic                   host_req_i,
   input  wire dbu_evt_t               debug_call_i,
   input  wire dbu_evt_t               dwatch_i,
   input  wire dbu_evt_t               rwatch_i,
   input  wire logic                   dbg_return_i,
   input  wire logic                   cfg_scr_we_i,
   input  wire logic [THR_SEL_W-1:0]   cfg_scr_idx_i,
   input  wire logic [31:0]            cfg_scr_wdata_i,
   output logic [31:0]                 cfg_scr_rdata_o,
   output logic                        dbg_irq_o,
   output logic [NUM_THREADS-1:0]      thread_stop_o,
   output logic [NUM_THREADS-1:0]      fetch_thread_o,
   output logic [FETCH_REG_W-1:0]      fetch_reg_o,
   output logic                        irq_o
);
   logic [1:0]          rst_sync_q;
   logic                rst_n;
   dbu_state_t          q;
   dbu_state_t          d;
   logic [NUM_IBRK-1:0] hit_w;
   logic                any_src;
   logic                entry;
   logic [1:0]          ib_low;
   logic [32:0]         rd_r;
   logic [32:0]         rd_w;
   logic [31:0]         m;
   logic [IRQ_W-1:0]    ev;
   logic [IRQ_W-1:0]    ist_clr;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Breakpoints only watch user code; the debug handler itself never hits.
   for (genvar g = 0; g < NUM_IBRK; g++) begin : g_ibrk
      dbu_ibrk_cmp u_cmp (
         .clk_i    (clk_i),
         .rst_n_i  (rst_n),
         .valid_i  (exec_valid_i && !q.in_dbg),
         .pc_i     (exec_pc_i),
         .thread_i (exec_thread_i),
         .target_i (q.ibt[g]),
         .cfg_i    (q.ibc[g]),
         .hit_o    (hit_w[g])
      );
   end

   // Returns the mapped flag above the word as software reads it.
   function automatic logic [32:0] rd_word(input dbu_state_t s,
                                           input dbu_idx_t   i);
      logic [32:0] r;
      r = '0;
      if (i == IDX_SAVED_STAT) r = {1'b1, 32'(s.saved_status_word)};
      if (i == IDX_SAVED_PC)   r = {1'b1, s.saved_program_counter_word};
      if (i == IDX_SAVED_SP)   r = {1'b1, s.saved_stack_pointer_word};
      if (i == IDX_FETCH_THR)  r = {1'b1, 32'(s.fetch_thr)};
      if (i == IDX_FETCH_REG)  r = {1'b1, 32'(s.fetch_reg)};
      if (i == IDX_CAUSE) begin
         r = {1'b1, 32'({s.cause.idx, s.cause.thread, 5'h00, s.cause.code})};
      end
      if (i == IDX_CAUSE_DATA) r = {1'b1, s.cause_data};
      if (i == IDX_STOP_MASK)  r = {1'b1, 32'(s.stop)};
      if (i == IDX_IRQ_STAT)   r = {1'b1, 32'(s.istat)};
      if (i == IDX_IRQ_MASK)   r = {1'b1, 32'(s.imask)};
      for (int n = 0; n < NUM_SCR; n++) begin
         if (i == IDX_SCRATCH + dbu_idx_t'(n)) r = {1'b1, s.scr[n]};
      end
      for (int n = 0; n < NUM_IBRK; n++) begin
         if (i == IDX_IBRK_TGT + dbu_idx_t'(n)) r = {1'b1, s.ibt[n]};
         if (i == IDX_IBRK_SETUP + dbu_idx_t'(n)) begin
            r = {1'b1, 32'({s.ibc[n].mask, 14'h0000, s.ibc[n].ne,
                            s.ibc[n].en})};
         end
      end
      return r;
   endfunction : rd_word

   // Merges write data into the old word under the byte strobes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[b*8 +: 8] = wd[b*8 +: 8];
      end
      return r;
   endfunction : merge

   assign any_src = host_req_i || debug_call_i.valid || (|hit_w) ||
                    dwatch_i.valid || rwatch_i.valid;
   assign entry   = any_src && !q.in_dbg;

   always_comb begin
      d       = q;
      ev      = '0;
      ib_low  = '0;
      ist_clr = '0;
      rd_r    = rd_word(q, axi_araddr_i[IDX_LSB +: IDX_W]);
      rd_w    = rd_word(q, q.aw_idx);
      m       = merge(rd_w[31:0], q.w_data, q.w_strb);
      for (int i = NUM_IBRK - 1; i >= 0; i--) begin
         if (hit_w[i]) ib_low = 2'(i);
      end

      // Read channel: answer one cycle after the address is taken.
      if (q.rvalid && axi_rready_i) d.rvalid = 1'b0;
      if (axi_arvalid_i && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_r[31:0];
         d.rresp  = rd_r[32] ? RESP_OKAY : RESP_SLVERR;
      end

      // Write channel: address and data are held until both are present.
      if (q.bvalid && axi_bready_i) d.bvalid = 1'b0;
      if (axi_awvalid_i && q.awready) begin
         d.aw_got = 1'b1;
         d.aw_idx = axi_awaddr_i[IDX_LSB +: IDX_W];
      end
      if (axi_wvalid_i && q.wready) begin
         d.w_got  = 1'b1;
         d.w_data = axi_wdata_i;
         d.w_strb = axi_wstrb_i;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
         if (q.aw_idx == IDX_SAVED_STAT) begin
            d.saved_status_word = (q.saved_status_word & ~STAT_WR_MASK) |
                                  (m[STAT_W-1:0] & STAT_WR_MASK);
         end
         if (q.aw_idx == IDX_SAVED_PC) d.saved_program_counter_word = m;
         if (q.aw_idx == IDX_SAVED_SP) d.saved_stack_pointer_word = m;
         if (q.aw_idx == IDX_FETCH_THR) begin
            d.fetch_thr = m[NUM_THREADS-1:0];
         end
         if (q.aw_idx == IDX_FETCH_REG) begin
            d.fetch_reg = m[FETCH_REG_W-1:0];
         end
         if (q.aw_idx == IDX_CAUSE) begin
            d.cause.idx    = m[CAUSE_IDX_LSB +: 2];
            d.cause.thread = m[CAUSE_THR_LSB +: NUM_THREADS];
            d.cause.code   = m[CAUSE_CODE_LSB +: 3];
         end
         if (q.aw_idx == IDX_CAUSE_DATA) d.cause_data = m;
         if (q.aw_idx == IDX_STOP_MASK) d.stop = m[NUM_THREADS-1:0];
         if (q.aw_idx == IDX_IRQ_MASK) d.imask = m[IRQ_W-1:0];
         if (q.aw_idx == IDX_IRQ_STAT) begin
            ist_clr = q.w_data[IRQ_W-1:0] & {IRQ_W{q.w_strb[0]}};
         end
         for (int n = 0; n < NUM_SCR; n++) begin
            if (q.aw_idx == IDX_SCRATCH + dbu_idx_t'(n)) d.scr[n] = m;
         end
         for (int n = 0; n < NUM_IBRK; n++) begin
            if (q.aw_idx == IDX_IBRK_TGT + dbu_idx_t'(n)) d.ibt[n] = m;
            if (q.aw_idx == IDX_IBRK_SETUP + dbu_idx_t'(n)) begin
               d.ibc[n].mask = m[IBC_MASK_LSB +: NUM_THREADS];
               d.ibc[n].ne   = m[IBC_NE_BIT];
               d.ibc[n].en   = m[IBC_EN_BIT];
            end
         end
      end

      // The configuration port shares the scratch words and wins a clash.
      if (cfg_scr_we_i) d.scr[cfg_scr_idx_i] = cfg_scr_wdata_i;
      d.cfg_rdata = q.scr[cfg_scr_idx_i];

      // Debug entry is applied last so a capture overrides a bus write.
      if (entry) begin
         d.in_dbg                     = 1'b1;
         d.saved_status_word          = snap_i.status & STAT_CAP_MASK;
         d.saved_program_counter_word = snap_i.pc;
         d.saved_stack_pointer_word   = snap_i.sp;
         ev[IRQ_ENTRY]                = 1'b1;
         if (host_req_i) begin
            d.cause = '{idx: 2'h0, thread: '0, code: CAUSE_HOST};
         end else if (debug_call_i.valid) begin
            d.cause = '{idx: 2'h0, thread: debug_call_i.thread,
                        code: CAUSE_CALL};
         end else if (|hit_w) begin
            d.cause = '{idx: ib_low, thread: exec_thread_i,
                        code: CAUSE_IBRK};
         end else if (dwatch_i.valid) begin
            d.cause = '{idx: dwatch_i.idx, thread: dwatch_i.thread,
                        code: CAUSE_DWATCH};
            d.cause_data = dwatch_i.data;
         end else begin
            d.cause = '{idx: rwatch_i.idx, thread: rwatch_i.thread,
                        code: CAUSE_RWATCH};
            d.cause_data = rwatch_i.data;
         end
      end else if (any_src) begin
         ev[IRQ_DROP] = 1'b1;
      end
      if (q.in_dbg && dbg_return_i) begin
         d.in_dbg       = 1'b0;
         ev[IRQ_RETURN] = 1'b1;
      end

      // A new event outweighs a clear written in the same cycle.
      d.istat    = (q.istat & ~ist_clr) | ev;
      d.irq      = |(d.istat & d.imask);
      d.stop_out = d.stop & {NUM_THREADS{!d.in_dbg}};
      d.awready  = !d.aw_got && !d.bvalid;
      d.wready   = !d.w_got && !d.bvalid;
      d.arready  = !d.rvalid;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign axi_awready_o   = q.awready;
   assign axi_wready_o    = q.wready;
   assign axi_bvalid_o    = q.bvalid;
   assign axi_bresp_o     = q.bresp;
   assign axi_arready_o   = q.arready;
   assign axi_rvalid_o    = q.rvalid;
   assign axi_rdata_o     = q.rdata;
   assign axi_rresp_o     = q.rresp;
   assign cfg_scr_rdata_o = q.cfg_rdata;
   assign dbg_irq_o       = q.in_dbg;
   assign thread_stop_o   = q.stop_out;
   assign fetch_thread_o  = q.fetch_thr;
   assign fetch_reg_o     = q.fetch_reg;
   assign irq_o           = q.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_entry;
      !q.in_dbg && any_src;
   endsequence
   sequence s_ibrk_entry;
      s_entry ##0 (!host_req_i && !debug_call_i.valid && (|hit_w));
   endsequence
   sequence s_dwatch_entry;
      s_entry ##0 (!host_req_i && !debug_call_i.valid && !(|hit_w) &&
                   dwatch_i.valid);
   endsequence

   a_status_capture: assert property (
      s_entry |=> q.saved_status_word == ($past(snap_i.status) & STAT_CAP_MASK))
      else $error("Saved status word not captured on entry.");
   a_status_rsvd: assert property (!q.saved_status_word[STAT_RSVD_BIT])
      else $error("Reserved status bit is set.");
   a_issue_mode_ro: assert property (
      (q.aw_got && q.w_got && q.aw_idx == IDX_SAVED_STAT && !entry) |=>
      $stable(q.saved_status_word[STAT_ISSUE_BIT]))
      else $error("Read-only issue mode bit changed by a write.");
   a_pc_capture: assert property (
      s_entry |=> q.saved_program_counter_word == $past(snap_i.pc))
      else $error("Program counter not captured on entry.");
   a_sp_capture: assert property (
      s_entry |=> q.saved_stack_pointer_word == $past(snap_i.sp))
      else $error("Stack pointer not captured on entry.");
   a_fetch_rsvd: assert property (
      (axi_arvalid_i && q.arready &&
       axi_araddr_i[IDX_LSB +: IDX_W] == IDX_FETCH_THR) |=>
      axi_rvalid_o && axi_rdata_o[31:NUM_THREADS] == '0 &&
      axi_rdata_o[NUM_THREADS-1:0] == $past(q.fetch_thr))
      else $error("Fetch thread operand read back wrong.");
   a_host_cause: assert property (
      (s_entry ##0 host_req_i) |=> q.cause.code == CAUSE_HOST &&
      q.cause.thread == '0 && q.cause.idx == 2'h0)
      else $error("Host entry recorded wrong cause.");
   a_low_index: assert property (
      (s_ibrk_entry ##0 (hit_w[1] && !hit_w[0])) |=>
      q.cause.idx == 2'h1 && q.cause.code == CAUSE_IBRK)
      else $error("Lowest breakpoint index not recorded.");
   a_call_thread: assert property (
      (s_entry ##0 (!host_req_i && debug_call_i.valid)) |=>
      q.cause.thread == $past(debug_call_i.thread) &&
      q.cause.code == CAUSE_CALL)
      else $error("Calling thread not recorded.");
   a_watch_data: assert property (
      s_dwatch_entry |=> q.cause_data == $past(dwatch_i.data))
      else $error("Watch address not captured.");
   a_stop_mask: assert property (
      !q.in_dbg |-> thread_stop_o == q.stop)
      else $error("Stop mask not applied outside debug mode.");
   a_scratch_share: assert property (
      cfg_scr_we_i |=> q.scr[$past(cfg_scr_idx_i)] == $past(cfg_scr_wdata_i))
      else $error("Configuration scratch write lost.");
   a_ibrk_entry: assert property (
      s_ibrk_entry |=> dbg_irq_o && q.cause.code == CAUSE_IBRK &&
      q.cause.thread == $past(exec_thread_i))
      else $error("Breakpoint hit did not enter debug.");
   a_write_answer: assert property (
      (q.aw_got && q.w_got) |=> axi_bvalid_o && !axi_awready_o)
      else $error("Write answer missing.");
endmodule : dbu_top
`default_nettype wire

// *** dbu_notes_end.sv ***
// Intentionally empty compilation unit marker.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** dbu_core_model.sv ***
// Core-side model that issues instructions and offers the entry snapshot.
`timescale 1ns/1ns
`default_nettype none
module dbu_core_model
   import dbu_pkg::*;
(
   input  wire logic [31:0]            pc_i,
   input  wire logic [NUM_THREADS-1:0] thr_i,
   input  wire logic                   issue_i,
   input  wire logic [NUM_THREADS-1:0] stop_i,
   output logic                        valid_o,
   output dbu_snap_t                   snap_o
);
   // A stopped thread never issues, however often it is asked to.
   assign valid_o = issue_i & ~stop_i[thr_i[2:0]];
   assign snap_o  = '{status: 11'h7ff, pc: pc_i, sp: ~pc_i};
endmodule : dbu_core_model
`default_nettype wire

// *** dbu_top_tb.sv ***
// Self-checking testbench of the debug breakpoint unit.
`timescale 1ns/1ns
`default_nettype none
module dbu_top_tb;
   import dbu_pkg::*;
   logic clk_i, resetn_i, axi_awvalid_i, axi_wvalid_i, axi_bready_i, issue,
      axi_arvalid_i, axi_rready_i, exec_valid_i, host_req_i, dbg_return_i,
      cfg_scr_we_i, axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o,
      axi_rvalid_o, dbg_irq_o, irq_o;
   logic [ADDR_W-1:0] axi_awaddr_i, axi_araddr_i;
   logic [31:0] axi_wdata_i, exec_pc_i, cfg_scr_wdata_i, cfg_scr_rdata_o,
      axi_rdata_o;
   logic [1:0] axi_bresp_o, axi_rresp_o;
   logic [NUM_THREADS-1:0] exec_thread_i, thread_stop_o, fetch_thread_o;
   logic [FETCH_REG_W-1:0] fetch_reg_o;
   dbu_snap_t snap_i;
   dbu_evt_t dwatch_i, debug_call_instruction, rwatch;
   int failures, samples_checked, cyc;
   dbu_top i_dut (.clk_i, .resetn_i, .axi_awaddr_i, .axi_awvalid_i,
      .axi_awready_o, .axi_wdata_i, .axi_wstrb_i(4'hf), .axi_wvalid_i,
      .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i,
      .axi_araddr_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o,
      .axi_rresp_o, .axi_rvalid_o, .axi_rready_i, .exec_valid_i, .exec_pc_i,
      .exec_thread_i, .snap_i, .host_req_i, .debug_call_i(debug_call_instruction), .dwatch_i,
      .rwatch_i(rwatch), .dbg_return_i, .cfg_scr_we_i, .cfg_scr_idx_i(3'h0),
      .cfg_scr_wdata_i, .cfg_scr_rdata_o, .dbg_irq_o, .thread_stop_o,
      .fetch_thread_o, .fetch_reg_o, .irq_o);
   dbu_core_model i_core (.pc_i(exec_pc_i), .thr_i(exec_thread_i),
      .issue_i(issue), .stop_i(thread_stop_o), .valid_o(exec_valid_i),
      .snap_o(snap_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      axi_awaddr_i <= a;
      axi_wdata_i <= d;
      axi_awvalid_i <= 1'b1;
      axi_wvalid_i <= 1'b1;
      axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (axi_awready_o) axi_awvalid_i <= 1'b0;
         if (axi_wready_o) axi_wvalid_i <= 1'b0;
      end while (!axi_bvalid_o);
      axi_bready_i <= 1'b0;
      chk({30'h0, axi_bresp_o}, {30'h0, RESP_OKAY});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] r = RESP_OKAY);
      @(posedge clk_i);
      axi_araddr_i <= a;
      axi_arvalid_i <= 1'b1;
      axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (axi_arready_o) axi_arvalid_i <= 1'b0;
      end while (!axi_rvalid_o);
      axi_rready_i <= 1'b0;
      chk(axi_rdata_o, e);
      chk({30'h0, axi_rresp_o}, {30'h0, r});
   endtask : rd
   task automatic pulse(input int k, input logic [31:0] p,
                        input logic [7:0] t);
      exec_pc_i <= p;
      exec_thread_i <= t;
      if (k == 0) host_req_i <= 1'b1;
      if (k == 1) issue <= 1'b1;
      if (k == 2) dbg_return_i <= 1'b1;
      if (k == 3) dwatch_i <= '{1'b1, 2'h2, 8'h6, 32'hcafe_0000};
      if (k == 4) debug_call_instruction <= '{1'b1, 2'h3, 8'h2, 32'h0};
      if (k == 5) rwatch <= '{1'b1, 2'h1, 8'h4, 32'h42};
      @(posedge clk_i);
      {host_req_i, issue, dbg_return_i} <= 3'h0;
      {dwatch_i, debug_call_instruction, rwatch} <= '0;
      repeat (2) @(posedge clk_i);
   endtask : pulse
   task automatic t_host;
      rd(12'h054, 32'h0);
      wr(12'h284, 32'h1);
      pulse(0, 32'h1234_5678, 8'h0);
      chk({30'h0, dbg_irq_o, irq_o}, 32'h3);
      rd(12'h054, 32'h1);
      rd(12'h044, 32'h1234_5678);
      rd(12'h048, 32'hedcb_a987);
      rd(12'h040, 32'h7df);
      wr(12'h040, 32'h0);
      rd(12'h040, 32'h100);
      wr(12'h280, 32'h1);
      pulse(2, 32'h0, 8'h0);
      chk({30'h0, dbg_irq_o, irq_o}, 32'h0);
   endtask : t_host
   task automatic t_bkpt;
      rd(12'h104, 32'h0);
      wr(12'h0c4, 32'h100);
      wr(12'h0c8, 32'h100);
      wr(12'h104, 32'h0008_0001);
      wr(12'h108, 32'h0008_0001);
      pulse(1, 32'h100, 8'h5);
      chk({31'h0, dbg_irq_o}, 32'h0);
      pulse(1, 32'h100, 8'h3);
      chk({31'h0, dbg_irq_o}, 32'h1);
      rd(12'h054, 32'h0001_0303);
      pulse(2, 32'h0, 8'h0);
      pulse(3, 32'h0, 8'h0);
      rd(12'h054, 32'h0002_0604);
      rd(12'h058, 32'hcafe_0000);
      pulse(2, 32'h0, 8'h0);
      wr(12'h10c, 32'hffff_ffff);
      rd(12'h10c, 32'h00ff_0003);
      pulse(1, 32'h200, 8'h7);
      rd(12'h054, 32'h0003_0703);
      pulse(2, 32'h0, 8'h0);
   endtask : t_bkpt
   task automatic t_misc;
      pulse(4, 32'h0, 8'h0);
      rd(12'h054, 32'h0000_0202);
      pulse(2, 32'h0, 8'h0);
      pulse(5, 32'h0, 8'h0);
      rd(12'h054, 32'h0001_0405);
      rd(12'h058, 32'h0000_0042);
      pulse(2, 32'h0, 8'h0);
      wr(12'h04c, 32'hffff_ffa5);
      rd(12'h04c, 32'h0000_00a5);
      wr(12'h050, 32'hffff_ffff);
      rd(12'h050, 32'h0000_001f);
      chk({19'h0, fetch_thread_o, fetch_reg_o}, 32'h0000_14bf);
      wr(12'h060, 32'hffff_ff08);
      repeat (2) @(posedge clk_i);
      chk({24'h0, thread_stop_o}, 32'h8);
      rd(12'h05c, 32'h0, RESP_SLVERR);
      cfg_scr_wdata_i <= 32'h5a5a_0001;
      cfg_scr_we_i <= 1'b1;
      @(posedge clk_i);
      cfg_scr_we_i <= 1'b0;
      rd(12'h080, 32'h5a5a_0001);
      chk(cfg_scr_rdata_o, 32'h5a5a_0001);
   endtask : t_misc
   task automatic final_report;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      {resetn_i, axi_awvalid_i, axi_wvalid_i, axi_bready_i, issue} = '0;
      {axi_arvalid_i, axi_rready_i, host_req_i, dbg_return_i} = '0;
      {axi_awaddr_i, axi_araddr_i, axi_wdata_i, exec_pc_i} = '0;
      {cfg_scr_we_i, cfg_scr_wdata_i, exec_thread_i, dwatch_i} = '0;
      {debug_call_instruction, rwatch} = '0;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_host();
      t_bkpt();
      t_misc();
      final_report();
   end
endmodule : dbu_top_tb
`default_nettype wire
